// ===== common/hlc_pkg.sv
package hlc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_ADDR_ONE = 5'h10;
  localparam logic [4:0] OFS_ADDR_TWO = 5'h11;
  localparam logic [4:0] OFS_CTRL_ONE = 5'h13;
  localparam logic [4:0] OFS_TAG_STAT = 5'h14;
  localparam logic [4:0] OFS_FIFO = 5'h16;
  localparam logic [4:0] OFS_SOFT_RST = 5'h1B;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_ADDR_REC = 7;
  localparam int C1_RX_EN = 6;
  localparam int C1_TX_EN = 5;
  localparam int C1_EOP = 4;
  localparam int C1_FA = 3;
  localparam int C1_FLAG_IDLE = 2;
  localparam int C1_LOOP_TX_RX = 1;
  localparam int C1_LOOP_RX_TX = 0;
  localparam int C14_FCS_INHIBIT = 3;
  localparam int C14_THR_MSB = 2;
  localparam int SRST_BIT = 0;
  localparam int ADDR_EN_BIT = 0;

  // ----------------------------------------------------------------
  // Line patterns, sizes and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAG_PAT = 8'h7E;
  localparam logic [7:0] ABORT_PAT = 8'hFE;
  localparam logic [6:0] ALL_CALL = 7'h7F;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
  localparam int FIFO_DEPTH = 128;
  localparam int FIFO_LVL_W = 8;
  localparam logic [7:0] THR_STEP = 8'h10;
  localparam logic [5:0] MIN_BITS = 6'h19;
  localparam logic [5:0] GOOD_BITS = 6'h20;
  localparam logic [5:0] ABORT_MIN_BITS = 6'h1A;
  localparam logic [3:0] IDLE_ONES = 4'hF;
  localparam logic [3:0] RX_STUFF_ONES = 4'h5;
  localparam logic [3:0] RX_FLAG_ONES = 4'h6;
  localparam logic [2:0] TX_STUFF_ONES = 3'h5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic eop;
    logic fa;
    logic [7:0] data;
  } hlc_tx_word_t;

  typedef struct packed {
    logic upper;
    logic lower;
    logic [7:0] data;
  } hlc_rx_word_t;

  typedef enum logic [5:0] {
    TX_IDLE = 6'h01,
    TX_FLAG = 6'h02,
    TX_DATA = 6'h04,
    TX_FCS = 6'h08,
    TX_CLOSE = 6'h10,
    TX_ABORT = 6'h20
  } hlc_tx_state_t;

endpackage

// ===== rtl/hlc_link_controller.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Byte FIFO
// ------------------------------------------------------------------
module hlc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 128
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clear_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  // Fill level
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } hlc_fifo_st_t;

  hlc_fifo_st_t s_reg;
  hlc_fifo_st_t s_next;
  logic [WIDTH-1:0] mem [DEPTH];

  assign level_o = s_reg.wp - s_reg.rp;
  assign in_ready_o = (level_o != (AW+1)'(DEPTH));
  assign out_valid_o = (s_reg.wp != s_reg.rp);
  assign out_data_o = mem[s_reg.rp[AW-1:0]];

  always_comb
  begin
    s_next = s_reg;
    if (in_valid_i && in_ready_o)
    begin
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (out_valid_o && out_ready_i)
    begin
      s_next.rp = s_reg.rp + 1'b1;
    end
    if (clear_i)
    begin
      s_next = '0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
    if (in_valid_i && in_ready_o)
    begin
      mem[s_reg.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ------------------------------------------------------------------
// Packet link controller
// ------------------------------------------------------------------
// Summary of operation
// R1 - On the national-bit link, run at the 4 to 20 kbit/s rate given by strobes.
// R2 - Own select bit in master control; when zero all controller events are masked.
// R3 - In signalling mode, alarm status stays visible and alarm transmit forces ones.
// R4 - 128-byte FIFOs; thresholds programmable 16 to 128 bytes in steps of 16.
// R5 - Frames open and close with 01111110; receiver hunts flags bit by bit.
// R6 - Receiver recognises single, dual and all-call addresses when enabled.
// R7 - Transmit complemented 16-bit FCS MSB first unless FCS insertion is inhibited.
// R8 - Receiver checks residue F0B8; mismatch tags the last byte as bad.
// R9 - Insert a zero after five ones in frames; receiver deletes it.
// R10 - Frames under 25 bits are dropped with nothing written.
// R11 - Frames of 25 to 31 bits are written with the last byte tagged bad.
// R12 - Good frames of 32 or more bits store data bytes, FCS discarded.
// R13 - Transmit abort is a zero then seven ones in place of the packet.
// R14 - Seven ones inside a packet of at least 26 bits abort and mark it bad.
// R15 - Fifteen or more consecutive ones is the idle state and is detected.
// R16 - Detect go-ahead 011111110, distinct from an in-packet abort; here an in-packet abort then a zero also raises go_ahead_o.
// R17 - Idle sends flags or ones; leave idle once a byte is in the FIFO.
// R18 - With FIFO empty after a packet send flags or ones per idle fill.
// R19 - Hard or soft reset clears control registers, disabling both directions.
// R20 - Independent transmit and receive enables and rates, both loopbacks.
// R21 - Each receive byte carries two tag bits readable at 14H.
// R22 - Transmit bytes carry end-of-packet and abort tags that are obeyed.
// R23 - After enabling idle sends ones; idle fill bit one selects flags.
// R24 - Tags: 11 last bad, 01 bad, 10 last good, 00 packet byte.
// R25 - An abort-tagged byte is replaced by an abort, then idle resumes.
// R26 - FIFO empty before an end or abort tag causes an abort.
// R27 - Data goes out LSB first, the FCS MSB first.
module hlc_link_controller (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Microprocessor port
  input wire logic [hlc_pkg::ADDR_W-1:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  output logic [7:0] cpu_rdata_o,
  output logic tx_fifo_ready_o,
  // Line side bit strobes and data
  input wire logic tx_bit_en_i,
  output logic tx_data_o,
  input wire logic rx_bit_en_i,
  input wire logic rx_data_i,
  // Master control and timeslot 16 signalling
  input wire logic ctrl_selected_i,
  input wire logic common_channel_signalling_mode_i,
  input wire logic ts16_alarm_transmit_i,
  input wire logic ts16_alarm_status_i,
  // Events and line state
  output logic rx_eop_o,
  output logic go_ahead_o,
  output logic idle_o
);
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctl14;
    logic [7:0] addr1;
    logic [7:0] addr2;
    logic [7:0] rdata;
    hlc_pkg::hlc_tx_state_t tx_state;
    logic [15:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [2:0] tx_ones;
    logic [15:0] tx_crc;
    logic tx_eop;
    logic tx_line;
    logic rx_frame;
    logic [3:0] rx_ones;
    logic [6:0] rx_dly;
    logic [2:0] rx_dcnt;
    logic [5:0] rx_bits;
    logic [15:0] rx_crc;
    logic [7:0] rx_asm;
    logic [2:0] rx_acnt;
    logic [2:0][7:0] rx_hold;
    logic [1:0] rx_hcnt;
    logic [1:0] rx_nbytes;
    logic rx_idle;
    logic ev_eop;
    logic ev_ga;
  } hlc_state_t;

  hlc_state_t s_reg;
  hlc_state_t s_next;

  hlc_pkg::hlc_tx_word_t txq_in;
  hlc_pkg::hlc_tx_word_t txq_out;
  hlc_pkg::hlc_rx_word_t rxq_in;
  hlc_pkg::hlc_rx_word_t rxq_out;
  logic txq_push;
  logic txq_pop;
  logic txq_valid;
  logic rxq_push;
  logic rxq_ready;
  logic rxq_pop;
  logic rxq_valid;
  logic fifo_clear;
  logic [hlc_pkg::FIFO_LVL_W-1:0] txq_level;
  logic [hlc_pkg::FIFO_LVL_W-1:0] rxq_level;

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b);
    crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? hlc_pkg::CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
    begin
      rev16[i] = v[15-i];
    end
  endfunction

  function automatic logic addr_ok(input logic [7:0] a, input logic [7:0] b);
    addr_ok = !a[hlc_pkg::ADDR_EN_BIT] || (b[7:1] == a[7:1]) || (b[7:1] == hlc_pkg::ALL_CALL);
  endfunction

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  hlc_fifo #(.WIDTH(10), .DEPTH(hlc_pkg::FIFO_DEPTH)) u_tx_fifo ( // see R4
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clear_i(fifo_clear),
    .in_valid_i(txq_push),
    .in_ready_o(tx_fifo_ready_o),
    .in_data_i(txq_in),
    .out_valid_o(txq_valid),
    .out_ready_i(txq_pop),
    .out_data_o(txq_out),
    .level_o(txq_level)
  );

  hlc_fifo #(.WIDTH(10), .DEPTH(hlc_pkg::FIFO_DEPTH)) u_rx_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clear_i(fifo_clear),
    .in_valid_i(rxq_push),
    .in_ready_o(rxq_ready),
    .in_data_i(rxq_in),
    .out_valid_o(rxq_valid),
    .out_ready_i(rxq_pop),
    .out_data_o(rxq_out),
    .level_o(rxq_level)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] thr;
    logic tx_stb;
    logic rx_stb;
    logic rbit;
    logic tbit;
    logic go;
    logic load;
    logic new_pkt;
    logic [3:0] ones;
    logic cb;
    logic bad;
    s_next = s_reg;
    s_next.ev_eop = 1'b0;
    s_next.ev_ga = 1'b0;
    txq_push = 1'b0;
    txq_pop = 1'b0;
    txq_in = '{eop: s_reg.ctrl1[hlc_pkg::C1_EOP], fa: s_reg.ctrl1[hlc_pkg::C1_FA],
               data: cpu_wdata_i};
    rxq_push = 1'b0;
    rxq_in = '0;
    rxq_pop = 1'b0;
    fifo_clear = 1'b0;
    load = 1'b0;
    new_pkt = 1'b0;
    tbit = 1'b0;
    cb = 1'b0;
    bad = 1'b0;
    ones = 4'h0;
    // Threshold is (n + 1) * 16, so codes 0 to 7 span 16 to 128 bytes.
    thr = 8'({5'h00, s_reg.ctl14[hlc_pkg::C14_THR_MSB:0]} + 8'h01) * hlc_pkg::THR_STEP; // see R4

    // Microprocessor writes.
    if (cpu_wr_i)
    begin
      unique case (cpu_addr_i)
        hlc_pkg::OFS_CTRL_ONE: s_next.ctrl1 = cpu_wdata_i; // see R20
        hlc_pkg::OFS_TAG_STAT: s_next.ctl14 = cpu_wdata_i;
        hlc_pkg::OFS_ADDR_ONE: s_next.addr1 = cpu_wdata_i;
        hlc_pkg::OFS_ADDR_TWO: s_next.addr2 = cpu_wdata_i;
        hlc_pkg::OFS_FIFO:
        begin
          txq_push = 1'b1; // see R22
          if (tx_fifo_ready_o)
          begin
            s_next.ctrl1[hlc_pkg::C1_EOP] = 1'b0;
            s_next.ctrl1[hlc_pkg::C1_FA] = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Microprocessor reads; the FIFO read pops the byte whose tags are shown at 14H.
    if (cpu_rd_i)
    begin
      unique case (cpu_addr_i)
        hlc_pkg::OFS_CTRL_ONE: s_next.rdata = s_reg.ctrl1;
        hlc_pkg::OFS_ADDR_ONE: s_next.rdata = s_reg.addr1;
        hlc_pkg::OFS_ADDR_TWO: s_next.rdata = s_reg.addr2;
        hlc_pkg::OFS_TAG_STAT: s_next.rdata = {rxq_out.upper, rxq_out.lower, // see R21
          !rxq_valid, (8'(rxq_level) >= thr), !tx_fifo_ready_o,
          (8'(txq_level) <= thr), s_reg.rx_idle, ts16_alarm_status_i}; // see R3
        hlc_pkg::OFS_FIFO:
        begin
          s_next.rdata = rxq_out.data;
          rxq_pop = 1'b1;
        end
        default: s_next.rdata = 8'h00;
      endcase
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    // A packet in flight is finished even after the enable drops.
    tx_stb = tx_bit_en_i && (s_reg.ctrl1[hlc_pkg::C1_TX_EN] || // see R1
             (s_reg.tx_state != hlc_pkg::TX_IDLE));
    go = s_reg.ctrl1[hlc_pkg::C1_TX_EN] && txq_valid; // see R17
    if (tx_stb)
    begin
      if (((s_reg.tx_state == hlc_pkg::TX_DATA) || (s_reg.tx_state == hlc_pkg::TX_FCS) ||
           ((s_reg.tx_state == hlc_pkg::TX_CLOSE) && (s_reg.tx_cnt == 4'h0))) &&
          (s_reg.tx_ones == hlc_pkg::TX_STUFF_ONES))
      begin
        s_next.tx_line = 1'b0; // see R9
        s_next.tx_ones = 3'h0;
      end
      else
      begin
        s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
        unique case (s_reg.tx_state)
          hlc_pkg::TX_IDLE:
          begin
            if (s_reg.ctrl1[hlc_pkg::C1_FLAG_IDLE])
            begin
              s_next.tx_line = hlc_pkg::FLAG_PAT[s_reg.tx_cnt[2:0]]; // see R23
              s_next.tx_cnt = {1'b0, s_reg.tx_cnt[2:0] + 3'h1};
              if ((s_reg.tx_cnt[2:0] == 3'h7) && go)
              begin
                load = 1'b1; // see R17
                new_pkt = 1'b1;
              end
            end
            else
            begin
              s_next.tx_line = 1'b1; // see R18
              s_next.tx_cnt = 4'h0;
              if (go)
              begin
                s_next.tx_state = hlc_pkg::TX_FLAG;
              end
            end
          end
          hlc_pkg::TX_FLAG:
          begin
            s_next.tx_line = hlc_pkg::FLAG_PAT[s_reg.tx_cnt[2:0]]; // see R5
            if (s_reg.tx_cnt[2:0] == 3'h7)
            begin
              load = 1'b1;
              new_pkt = 1'b1;
            end
          end
          hlc_pkg::TX_DATA:
          begin
            tbit = s_reg.tx_sh[0]; // see R27
            s_next.tx_line = tbit;
            s_next.tx_sh = {1'b0, s_reg.tx_sh[15:1]};
            s_next.tx_crc = crc_step(s_reg.tx_crc, tbit); // see R7
            s_next.tx_ones = tbit ? s_reg.tx_ones + 3'h1 : 3'h0;
            if (s_reg.tx_cnt[2:0] == 3'h7)
            begin
              s_next.tx_cnt = 4'h0;
              if (!s_reg.tx_eop)
              begin
                load = 1'b1;
              end
              else if (s_reg.ctl14[hlc_pkg::C14_FCS_INHIBIT])
              begin
                s_next.tx_state = hlc_pkg::TX_CLOSE; // see R7
              end
              else
              begin
                s_next.tx_state = hlc_pkg::TX_FCS;
                s_next.tx_sh = ~s_next.tx_crc; // see R7
              end
            end
          end
          hlc_pkg::TX_FCS:
          begin
            tbit = s_reg.tx_sh[15]; // see R27
            s_next.tx_line = tbit;
            s_next.tx_sh = {s_reg.tx_sh[14:0], 1'b0};
            s_next.tx_ones = tbit ? s_reg.tx_ones + 3'h1 : 3'h0;
            if (s_reg.tx_cnt == 4'hF)
            begin
              s_next.tx_state = hlc_pkg::TX_CLOSE;
            end
          end
          hlc_pkg::TX_CLOSE:
          begin
            s_next.tx_line = hlc_pkg::FLAG_PAT[s_reg.tx_cnt[2:0]]; // see R5
            s_next.tx_ones = 3'h0;
            if (s_reg.tx_cnt[2:0] == 3'h7)
            begin
              s_next.tx_cnt = 4'h0;
              s_next.tx_state = hlc_pkg::TX_IDLE; // see R18
              if (go)
              begin
                load = 1'b1;
                new_pkt = 1'b1;
              end
            end
          end
          hlc_pkg::TX_ABORT:
          begin
            s_next.tx_line = hlc_pkg::ABORT_PAT[s_reg.tx_cnt[2:0]]; // see R13
            s_next.tx_ones = 3'h0;
            if (s_reg.tx_cnt[2:0] == 3'h7)
            begin
              s_next.tx_cnt = 4'h0;
              s_next.tx_state = hlc_pkg::TX_IDLE; // see R25
            end
          end
          default:
          begin
            s_next.tx_state = hlc_pkg::TX_IDLE;
          end
        endcase
      end
    end
    if (load)
    begin
      s_next.tx_cnt = 4'h0;
      s_next.tx_ones = new_pkt ? 3'h0 : s_next.tx_ones;
      s_next.tx_crc = new_pkt ? hlc_pkg::CRC_INIT : s_next.tx_crc;
      txq_pop = txq_valid;
      if (!txq_valid || txq_out.fa)
      begin
        s_next.tx_state = hlc_pkg::TX_ABORT; // see R25 see R26
      end
      else
      begin
        s_next.tx_state = hlc_pkg::TX_DATA;
        s_next.tx_sh = {8'h00, txq_out.data};
        s_next.tx_eop = txq_out.eop; // see R22
      end
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    rx_stb = s_reg.ctrl1[hlc_pkg::C1_RX_EN] &&
             (s_reg.ctrl1[hlc_pkg::C1_LOOP_TX_RX] ? tx_bit_en_i : rx_bit_en_i); // see R20
    rbit = s_reg.ctrl1[hlc_pkg::C1_LOOP_TX_RX] ? s_reg.tx_line : rx_data_i;
    if (rx_stb)
    begin
      ones = rbit ? ((s_reg.rx_ones == 4'hF) ? 4'hF : s_reg.rx_ones + 4'h1) : 4'h0;
      s_next.rx_ones = ones;
      s_next.rx_idle = (ones >= hlc_pkg::IDLE_ONES); // see R15
      if (!rbit && (s_reg.rx_ones == hlc_pkg::RX_FLAG_ONES))
      begin
        // Closing flag: the delay line holds flag bits only, so it is dropped.
        if (s_reg.rx_frame && (s_reg.rx_bits >= hlc_pkg::MIN_BITS) && (s_reg.rx_hcnt != 2'h0))
        begin
          bad = (s_reg.rx_bits < hlc_pkg::GOOD_BITS) || (s_reg.rx_bits[2:0] != 3'h0) || // see R11
                (rev16(s_reg.rx_crc) != hlc_pkg::CRC_RESIDUE); // see R8
          rxq_push = 1'b1;
          rxq_in = '{upper: 1'b1, lower: bad, data: s_reg.rx_hold[0]}; // see R12 see R24
          s_next.ev_eop = 1'b1;
        end
        s_next.rx_frame = 1'b1; // see R5 see R10
        s_next.rx_dcnt = 3'h0;
        s_next.rx_bits = 6'h00;
        s_next.rx_crc = hlc_pkg::CRC_INIT;
        s_next.rx_acnt = 3'h0;
        s_next.rx_hcnt = 2'h0;
        s_next.rx_nbytes = 2'h0;
      end
      else if (!rbit && (s_reg.rx_ones == 4'h7))
      begin
        s_next.ev_ga = !s_reg.rx_frame; // see R16
        s_next.rx_frame = 1'b0;
      end
      else if (rbit && (s_reg.rx_ones == hlc_pkg::RX_FLAG_ONES))
      begin
        if (s_reg.rx_frame && (s_reg.rx_bits >= hlc_pkg::ABORT_MIN_BITS) &&
            (s_reg.rx_hcnt != 2'h0))
        begin
          rxq_push = 1'b1;
          rxq_in = '{upper: 1'b1, lower: 1'b1, data: s_reg.rx_hold[0]}; // see R14
          s_next.ev_eop = 1'b1;
        end
        s_next.rx_frame = 1'b0;
      end
      else if (s_reg.rx_frame && !(!rbit && (s_reg.rx_ones == hlc_pkg::RX_STUFF_ONES))) // see R9
      begin
        // Seven bits of delay keep a closing flag out of the data path.
        s_next.rx_dly = {rbit, s_reg.rx_dly[6:1]};
        if (s_reg.rx_dcnt == 3'h7)
        begin
          cb = s_reg.rx_dly[0];
          s_next.rx_crc = crc_step(s_reg.rx_crc, cb);
          s_next.rx_bits = (s_reg.rx_bits[5:3] == 3'h7) ?
            {3'h7, s_reg.rx_bits[2:0] + 3'h1} : s_reg.rx_bits + 6'h01;
          s_next.rx_asm = {cb, s_reg.rx_asm[7:1]};
          s_next.rx_acnt = s_reg.rx_acnt + 3'h1;
          if (s_reg.rx_acnt == 3'h7)
          begin
            s_next.rx_nbytes = (s_reg.rx_nbytes == 2'h3) ? 2'h3 : s_reg.rx_nbytes + 2'h1;
            if (s_reg.ctrl1[hlc_pkg::C1_ADDR_REC] &&
                (((s_reg.rx_nbytes == 2'h0) && !addr_ok(s_reg.addr1, s_next.rx_asm)) ||
                 ((s_reg.rx_nbytes == 2'h1) && !addr_ok(s_reg.addr2, s_next.rx_asm))))
            begin
              s_next.rx_frame = 1'b0; // see R6
            end
            else if (s_reg.rx_hcnt == 2'h3)
            begin
              // The two newest bytes may be the FCS, so they stay held.
              rxq_push = 1'b1;
              rxq_in = '{upper: 1'b0, lower: 1'b0, data: s_reg.rx_hold[0]}; // see R24
              s_next.rx_hold = {s_next.rx_asm, s_reg.rx_hold[2:1]};
            end
            else
            begin
              s_next.rx_hold[s_reg.rx_hcnt] = s_next.rx_asm;
              s_next.rx_hcnt = s_reg.rx_hcnt + 2'h1;
            end
          end
        end
        else
        begin
          s_next.rx_dcnt = s_reg.rx_dcnt + 3'h1;
        end
      end
      // On overflow the rest of the packet is dropped until the next flag.
      if (rxq_push && !rxq_ready)
      begin
        s_next.rx_frame = 1'b0;
        s_next.ev_eop = 1'b0;
      end
    end

    // Soft reset clears every control register and flushes the datapath.
    if (cpu_wr_i && (cpu_addr_i == hlc_pkg::OFS_SOFT_RST) && cpu_wdata_i[hlc_pkg::SRST_BIT])
    begin
      s_next = '0; // see R19
      s_next.tx_state = hlc_pkg::TX_IDLE;
      s_next.tx_line = 1'b1;
      fifo_clear = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0; // see R19
      s_reg.ctrl1 <= hlc_pkg::REG_RESET;
      s_reg.tx_state <= hlc_pkg::TX_IDLE;
      s_reg.tx_line <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Alarm transmit outranks the packet stream only in signalling mode.
  assign tx_data_o = (common_channel_signalling_mode_i && ts16_alarm_transmit_i) ? 1'b1 : // see R3
                     (s_reg.ctrl1[hlc_pkg::C1_LOOP_RX_TX] ? rx_data_i : s_reg.tx_line); // see R20
  assign cpu_rdata_o = s_reg.rdata;
  assign rx_eop_o = s_reg.ev_eop && ctrl_selected_i; // see R2
  assign go_ahead_o = s_reg.ev_ga && ctrl_selected_i; // see R2
  assign idle_o = s_reg.rx_idle;
endmodule

// ===== testbench/hlc_link_controller_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module hlc_link_controller_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic [hlc_pkg::ADDR_W-1:0] cpu_addr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_rdata_o,
  input wire logic tx_data_o,
  input wire logic rx_bit_en_i,
  input wire logic rx_data_i,
  input wire logic ctrl_selected_i,
  input wire logic common_channel_signalling_mode_i,
  input wire logic ts16_alarm_transmit_i,
  input wire logic rx_eop_o,
  input wire logic go_ahead_o,
  input wire logic idle_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  eop_mask_a: assert property (!ctrl_selected_i |-> !rx_eop_o)
    else $error("end of packet pulse while deselected");
  ga_mask_a: assert property (!ctrl_selected_i |-> !go_ahead_o)
    else $error("go ahead pulse while deselected");
  alarm_ones_a: assert property (
    common_channel_signalling_mode_i && ts16_alarm_transmit_i |-> tx_data_o)
    else $error("alarm transmit not forcing ones");
  reset_state_a: assert property (
    $fell(rst_i) |-> tx_data_o && cpu_rdata_o == 8'h00 && !idle_o)
    else $error("wrong state after reset");
  eop_strobe_a: assert property (rx_eop_o |-> $past(rx_bit_en_i))
    else $error("end of packet pulse without a bit strobe");
  ga_strobe_a: assert property (go_ahead_o |-> $past(rx_bit_en_i) && !$past(rx_data_i))
    else $error("go ahead without a closing zero");
  idle_ones_a: assert property (
    $rose(idle_o) |-> $past(rx_bit_en_i) && $past(rx_data_i))
    else $error("idle raised without a received one");
  srst_read_a: assert property (
    cpu_rd_i && cpu_addr_i == hlc_pkg::OFS_SOFT_RST |=> cpu_rdata_o == 8'h00)
    else $error("soft reset register not reading zero");
  cover property (rx_eop_o);
  cover property ($rose(idle_o));
  cover property (common_channel_signalling_mode_i && ts16_alarm_transmit_i);
endmodule

// ===== testbench/hlc_far_station.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far station that echoes the line back
// ----------------------------------------
module hlc_far_station #(
  parameter int DIV = 4
) (
  input wire logic clk_sys_i,
  input wire logic tx_data_i,
  output logic tx_bit_en_o = 1'b0,
  output logic rx_bit_en_o = 1'b0,
  output logic rx_data_o = 1'b1
);
  int cnt = 0;
  // Receive strobe trails transmit so the echoed bit has settled.
  always @(negedge clk_sys_i)
  begin
    cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
    tx_bit_en_o <= (cnt == 0);
    rx_bit_en_o <= (cnt == 2);
    if (cnt == 1)
      rx_data_o <= tx_data_i;
  end
endmodule

// ===== testbench/hlc_link_controller_test.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module hlc_link_controller_test;
  logic [hlc_pkg::ADDR_W-1:0] adr = '0;
  logic [7:0] wd = 8'h00, rdo, v;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, wr_s = 1'b0, rd_s = 1'b0, sel = 1'b1;
  logic common_channel_signalling_mode = 1'b0, atx = 1'b0, ast = 1'b1, txb, txd, rxb, rxd, eop, ga, idle, rdy;
  int bad_count = 0, compares = 0, cyc = 0;
  hlc_link_controller u_hlc_link_controller (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .cpu_addr_i(adr), .cpu_wdata_i(wd), .cpu_wr_i(wr_s), .cpu_rd_i(rd_s), .cpu_rdata_o(rdo),
    .tx_fifo_ready_o(rdy), .tx_bit_en_i(txb), .tx_data_o(txd), .rx_bit_en_i(rxb),
    .rx_data_i(rxd), .ctrl_selected_i(sel), .common_channel_signalling_mode_i(common_channel_signalling_mode),
    .ts16_alarm_transmit_i(atx), .ts16_alarm_status_i(ast), .rx_eop_o(eop),
    .go_ahead_o(ga), .idle_o(idle));
  hlc_far_station u_hlc_far_station (.clk_sys_i(clk_sys_i), .tx_data_i(txd),
    .tx_bit_en_o(txb), .rx_bit_en_o(rxb), .rx_data_o(rxd));
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task end_of_test;
    $display("Counts: compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    adr = a;
    wd = d;
    wr_s = 1'b1;
    @(negedge clk_sys_i);
    wr_s = 1'b0;
  endtask
  task rd(input logic [4:0] a);
    @(negedge clk_sys_i);
    adr = a;
    rd_s = 1'b1;
    @(negedge clk_sys_i);
    rd_s = 1'b0;
    v = rdo;
  endtask
  // The last byte goes in after the tag write, as the tag rides on the next FIFO write.
  task frame(input logic [7:0] q[$], input logic [7:0] c, input logic [1:0] lt);
    int i;
    for (i = 0; i < q.size() - 1; i++)
      wr(hlc_pkg::OFS_FIFO, q[i]);
    wr(hlc_pkg::OFS_CTRL_ONE, c);
    wr(hlc_pkg::OFS_FIFO, q[q.size() - 1]);
    for (i = 0; i < 3000 && eop !== 1'b1; i++)
      @(negedge clk_sys_i);
    chk("end of packet", {7'h00, eop}, 8'h01);
    i = 0;
    rd(hlc_pkg::OFS_TAG_STAT);
    while (v[7] !== 1'b1 && i < 8)
    begin
      rd(hlc_pkg::OFS_FIFO);
      chk("rx byte", v, q[i]);
      i++;
      rd(hlc_pkg::OFS_TAG_STAT);
    end
    chk("rx tag", v & 8'hC0, {lt, 6'h00});
    rd(hlc_pkg::OFS_FIFO);
    chk("rx last", v, q[i]);
    rd(hlc_pkg::OFS_TAG_STAT);
    chk("rx empty", v & 8'h20, 8'h20);
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (8) @(negedge clk_sys_i);
    rst_i = 1'b0;
    rd(hlc_pkg::OFS_CTRL_ONE);
    chk("ctrl one", v, 8'h00);
    rd(5'h01);
    chk("unmapped", v, 8'h00);
    chk("tx ready", {7'h00, rdy}, 8'h01);
    $display("test reset done");
    wr(hlc_pkg::OFS_CTRL_ONE, 8'h64);
    frame({8'hAA, 8'h03, 8'h77}, 8'h74, 2'b10);
    $display("test good frame done");
    frame({8'h11, 8'h22, 8'h33, 8'h44, 8'h00}, 8'h6C, 2'b11);
    $display("test abort done");
    sel = 1'b0;
    common_channel_signalling_mode = 1'b1;
    atx = 1'b1;
    wr(hlc_pkg::OFS_CTRL_ONE, 8'h60);
    for (int i = 0; i < 1000 && idle !== 1'b1; i++)
      @(negedge clk_sys_i);
    rd(hlc_pkg::OFS_TAG_STAT);
    chk("idle status", v & 8'h03, 8'h03);
    $display("test idle done");
    sel = 1'b1;
    wr(hlc_pkg::OFS_SOFT_RST, 8'h01);
    rd(hlc_pkg::OFS_CTRL_ONE);
    chk("ctrl after soft reset", v, 8'h00);
    rd(hlc_pkg::OFS_SOFT_RST);
    $display("test soft reset done");
    end_of_test;
  end
endmodule
bind hlc_link_controller hlc_link_controller_chk u_hlc_link_controller_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i),
  .cpu_rdata_o(cpu_rdata_o), .tx_data_o(tx_data_o), .rx_bit_en_i(rx_bit_en_i),
  .rx_data_i(rx_data_i), .ctrl_selected_i(ctrl_selected_i),
  .common_channel_signalling_mode_i(common_channel_signalling_mode_i),
  .ts16_alarm_transmit_i(ts16_alarm_transmit_i), .rx_eop_o(rx_eop_o),
  .go_ahead_o(go_ahead_o), .idle_o(idle_o));
